// ---- include/odw_consts.vh ----
// constants for the octal converter serial write port
// assumes inclusion by bare name from src/ files
// What this block does
// - while frame-sync low, shift register enabled, data sampled on falling clock edges
// - input shift register is 32 bits, one bit per falling edge
// - converter output updates only after the 32nd falling edge
// - frame-sync high before 31st edge aborts; partial word discarded, outputs unchanged
// - load strobe gives asynchronous and synchronous update modes, chosen by host
`ifndef ODW_CONSTS_VH
`define ODW_CONSTS_VH
`define ODW_WORD_BITS     32
`define ODW_CNT_BITS      6
`define ODW_LAST_EDGE     6'h20
`define ODW_ABORT_EDGE    6'h1F
`define ODW_CHAN_BITS     3
`define ODW_CODE_BITS     16
`define ODW_CODE_LSB      4
`define ODW_CHAN_LSB      20
`define ODW_POR_CODE      16'h0000
`define ODW_FIFO_DEPTH    8
`define ODW_FIFO_AW       3
`define ODW_SYS_PERIOD_PS 8000
`define ODW_CLR_MIN_NS    80
`define ODW_CLR_CYCLES    ((`ODW_CLR_MIN_NS * 1000 + `ODW_SYS_PERIOD_PS - 1) / `ODW_SYS_PERIOD_PS)
`endif

// ---- src/odw_fifo.v ----
// parameterised word FIFO with valid/ready on both sides
// assumes a single clock domain, async active-low reset
`timescale 1ns/1ps
module odw_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             sys_clk,
    input  wire             resetn,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            full;
    wire            empty;
    wire            do_wr;
    wire            do_rd;

    assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty     = (wr_ptr == rd_ptr);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign do_wr     = in_valid && !full;
    assign do_rd     = out_ready && !empty;

    always @(posedge sys_clk)
    begin
        if (do_wr)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else if (flush)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
                wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
            if (do_rd)
                rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
        end
    end
endmodule

// ---- src/odw_write_port.v ----
// serial write front end: frame-sync, serial clock, data, load strobe, clear
// assumes all pins asynchronous to sys_clk; serial clock well below sys_clk/2
`timescale 1ns/1ps
`include "odw_consts.vh"
module odw_write_port (
    input  wire                        sys_clk,
    input  wire                        resetn,
    input  wire                        sync_n,
    input  wire                        sclk,
    input  wire                        sdin,
    input  wire                        load_strobe_n,
    input  wire                        clear_n,
    output reg  [8*`ODW_CODE_BITS-1:0] dac_code,
    output reg  [7:0]                  dac_updated,
    output reg                         word_ready,
    output reg                         frame_abort
);
    // two-flop synchronisers; logic reads the second stage and, for edge detection, its delayed copy
    reg [4:0] s1;
    reg [4:0] s2;
    reg       sclk_d;
    reg       sync_d;
    reg       ld_d;
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1     <= 5'h1F;
            s2     <= 5'h1F;
            sclk_d <= 1'b1;
            sync_d <= 1'b1;
            ld_d   <= 1'b1;
        end
        else
        begin
            s1     <= {sync_n, sclk, sdin, load_strobe_n, clear_n};
            s2     <= s1;
            sclk_d <= s2[3];
            sync_d <= s2[4];
            ld_d   <= s2[1];
        end
    end
    wire sync_q  = s2[4];
    wire sclk_q  = s2[3];
    wire din_q   = s2[2];
    wire ld_q    = s2[1];
    wire clr_q   = s2[0];
    wire sclk_fall = sclk_d && !sclk_q;
    wire sync_rise = !sync_d && sync_q;
    wire ld_fall   = ld_d && !ld_q;

    reg [`ODW_WORD_BITS-1:0] shreg;
    reg [`ODW_CNT_BITS-1:0]  edges;
    reg                      frame_done;
    wire [`ODW_WORD_BITS-1:0] next_shreg = {shreg[`ODW_WORD_BITS-2:0], din_q};
    wire                     fifo_in_ready;

    // shift engine
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shreg       <= {`ODW_WORD_BITS{1'b0}};
            edges       <= {`ODW_CNT_BITS{1'b0}};
            frame_done  <= 1'b0;
            frame_abort <= 1'b0;
        end
        else
        begin
            frame_done  <= 1'b0;
            frame_abort <= 1'b0;
            if (sync_q)
            begin
                // short frame aborts; a frame stopped at edge 31 is just not complete
                if (sync_rise && edges < `ODW_ABORT_EDGE)
                    frame_abort <= 1'b1;
                edges <= {`ODW_CNT_BITS{1'b0}};
            end
            else if (sclk_fall && edges < `ODW_LAST_EDGE)
            begin
                shreg <= next_shreg;
                edges <= edges + 6'h01;
                if (edges == `ODW_LAST_EDGE - 6'h01)
                    frame_done <= fifo_in_ready;
            end
        end
    end

    // completed words queue here; full queue drops the word at source
    wire [`ODW_WORD_BITS-1:0] q_data;
    wire                      q_valid;
    reg                       q_take;
    odw_fifo #(
        .WIDTH (`ODW_WORD_BITS),
        .DEPTH (`ODW_FIFO_DEPTH),
        .AW    (`ODW_FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .flush     (!clr_q),
        .in_data   (shreg),
        .in_valid  (frame_done),
        .in_ready  (fifo_in_ready),
        .out_data  (q_data),
        .out_valid (q_valid),
        .out_ready (q_take)
    );

    // input registers per channel, then converter registers
    reg [8*`ODW_CODE_BITS-1:0] in_code;
    reg [7:0]                  pend;
    wire [2:0]  q_ch   = q_data[`ODW_CHAN_LSB +: `ODW_CHAN_BITS];
    wire [15:0] q_code = q_data[`ODW_CODE_LSB +: `ODW_CODE_BITS];
    // async mode: strobe already low when word completes -> immediate update
    wire        async_go = !ld_q;
    always @*
    begin
        q_take = q_valid;
    end

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_ch
            wire hit = q_take && (q_ch == g);
            always @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    in_code[g*16 +: 16]  <= `ODW_POR_CODE;
                    dac_code[g*16 +: 16] <= `ODW_POR_CODE;
                    pend[g]              <= 1'b0;
                    dac_updated[g]       <= 1'b0;
                end
                else if (!clr_q)
                begin
                    in_code[g*16 +: 16]  <= `ODW_POR_CODE;
                    dac_code[g*16 +: 16] <= `ODW_POR_CODE;
                    pend[g]              <= 1'b0;
                    dac_updated[g]       <= 1'b0;
                end
                else
                begin
                    dac_updated[g] <= 1'b0;
                    if (hit)
                        in_code[g*16 +: 16] <= q_code;
                    if (hit && async_go)
                    begin
                        dac_code[g*16 +: 16] <= q_code;
                        dac_updated[g]       <= 1'b1;
                        pend[g]              <= 1'b0;
                    end
                    else if (ld_fall && pend[g])
                    begin
                        // sync mode: strobe falling edge loads held codes
                        dac_code[g*16 +: 16] <= in_code[g*16 +: 16];
                        dac_updated[g]       <= 1'b1;
                        pend[g]              <= hit;
                    end
                    else if (hit)
                        pend[g] <= 1'b1;
                end
            end
        end
    endgenerate

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            word_ready <= 1'b0;
        else
            word_ready <= frame_done;
    end
endmodule

// ---- verif/odw_host_model.sv ----
// host side model: drives frame-sync, serial clock and data
// assumes sys_clk at 8 ns; serial clock made at 64 ns period
`timescale 1ns/1ps
module odw_host_model (
    input  wire sys_clk,
    output reg  sync_n,
    output reg  sclk,
    output reg  sdin
);
    initial
    begin
        sync_n = 1'b1;
        sclk   = 1'b1;
        sdin   = 1'b0;
    end

    // msb first; n below 32 cuts the frame short
    task send(input [31:0] w, input integer n);
        integer i;
        begin
            @(posedge sys_clk) sync_n <= 1'b0;
            for (i = 0; i < n; i = i + 1)
            begin
                sdin <= w[31-i];
                repeat (4) @(posedge sys_clk);
                sclk <= 1'b0;
                repeat (4) @(posedge sys_clk);
                sclk <= 1'b1;
            end
            sync_n <= 1'b1;
            // released data line must not keep the last bit
            sdin <= ~sdin;
            repeat (12) @(posedge sys_clk);
        end
    endtask
endmodule

// ---- verif/odw_monitor.sv ----
// port checker for the serial write port
// assumes binding onto odw_write_port, one clock domain
`timescale 1ns/1ps
module odw_monitor (
    input wire         sys_clk,
    input wire         resetn,
    input wire         sync_n,
    input wire         sclk,
    input wire         sdin,
    input wire         load_strobe_n,
    input wire         clear_n,
    input wire [127:0] dac_code,
    input wire [7:0]   dac_updated,
    input wire         word_ready,
    input wire         frame_abort
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    word_pulse_a: assert property (word_ready |=> !word_ready)
        else $error("word ready longer than one cycle");
    abort_pulse_a: assert property (frame_abort |=> !frame_abort)
        else $error("abort longer than one cycle");
    abort_excl_a: assert property (!(word_ready && frame_abort))
        else $error("word and abort together");
    code_cause_a: assert property ($changed(dac_code) && clear_n && $past(clear_n, 4)
        |-> dac_updated != 8'h00) else $error("code changed without update");
    clear_code_a: assert property (!clear_n [*5] |-> dac_code == 128'h0)
        else $error("clear did not zero codes");
    clear_quiet_a: assert property (!clear_n [*5] |-> dac_updated == 8'h00)
        else $error("update while clear held");
    async_load_a: assert property (word_ready && !load_strobe_n && clear_n
        |-> ##[1:4] dac_updated != 8'h00) else $error("strobe low word not loaded");
    sync_hold_a: assert property (load_strobe_n [*5] ##0 word_ready
        |=> dac_updated == 8'h00) else $error("loaded with strobe high");
endmodule

// ---- verif/test_odw_write_port.sv ----
// self-checking bench for the serial write port
// assumes host model drives the serial pins, bench drives strobe and clear
`timescale 1ns/1ps
module test_odw_write_port;
    reg          sys_clk = 1'b0;
    reg          resetn = 1'b0;
    reg          load_strobe_n = 1'b0;
    reg          clear_n = 1'b1;
    wire         sync_n;
    wire         sclk;
    wire         sdin;
    wire [127:0] dac_code;
    wire [7:0]   dac_updated;
    wire         word_ready;
    wire         frame_abort;
    integer      bad_count = 0;
    integer      n_checks = 0;
    integer      n_word = 0;
    integer      n_abort = 0;
    integer      n_upd = 0;
    integer      g;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        n_word  <= n_word + word_ready;
        n_abort <= n_abort + frame_abort;
        n_upd   <= n_upd + (dac_updated != 8'h00);
    end
    odw_host_model host (.sys_clk(sys_clk), .sync_n(sync_n), .sclk(sclk), .sdin(sdin));
    odw_write_port uut (.sys_clk(sys_clk), .resetn(resetn), .sync_n(sync_n), .sclk(sclk),
        .sdin(sdin), .load_strobe_n(load_strobe_n), .clear_n(clear_n), .dac_code(dac_code),
        .dac_updated(dac_updated), .word_ready(word_ready), .frame_abort(frame_abort));
    task check(input string what, input [31:0] exp, input [31:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp)
            begin
                bad_count = bad_count + 1;
                $display("mismatch %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, bad_count);
            if (bad_count == 0 && n_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    function [31:0] word(input [2:0] ch, input [15:0] code);
        word = {9'h000, ch, code, 4'h0};
    endfunction
    task t_async;
        integer k;
        integer u;
        for (g = 0; g < 8; g = g + 1)
        begin
            k = n_word;
            u = n_upd;
            host.send(word(g, 16'hA5C3 ^ g), 32);
            repeat (8) @(posedge sys_clk);
            check("word count", k + 1, n_word);
            check("update count", u + 1, n_upd);
            check("code", 16'hA5C3 ^ g, dac_code[g*16+:16]);
        end
    endtask
    task t_abort;
        integer k;
        begin
            k = n_abort;
            host.send(word(5, 16'h0F0F), 30);
            repeat (8) @(posedge sys_clk);
            check("abort count", k + 1, n_abort);
            check("code", 16'hA5C3 ^ 5, dac_code[80+:16]);
        end
    endtask
    task t_sync;
        begin
            @(posedge sys_clk) load_strobe_n <= 1'b1;
            host.send(word(6, 16'h5A5A), 32);
            repeat (8) @(posedge sys_clk);
            check("held code", 16'hA5C3 ^ 6, dac_code[96+:16]);
            @(posedge sys_clk) load_strobe_n <= 1'b0;
            repeat (12) @(posedge sys_clk);
            check("loaded code", 16'h5A5A, dac_code[96+:16]);
        end
    endtask
    task t_clear;
        begin
            @(posedge sys_clk) clear_n <= 1'b0;
            repeat (12) @(posedge sys_clk);
            for (g = 0; g < 8; g = g + 1)
                check("cleared code", 16'h0000, dac_code[g*16+:16]);
            @(posedge sys_clk) clear_n <= 1'b1;
        end
    endtask
    initial
    begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_async;
        t_abort;
        t_sync;
        t_clear;
        finish_test;
    end
    // whole run needs about 2800 cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        bad_count = bad_count + 1;
        finish_test;
    end
endmodule
bind odw_write_port odw_monitor mon (.sys_clk(sys_clk), .resetn(resetn), .sync_n(sync_n),
    .sclk(sclk), .sdin(sdin), .load_strobe_n(load_strobe_n), .clear_n(clear_n),
    .dac_code(dac_code), .dac_updated(dac_updated), .word_ready(word_ready),
    .frame_abort(frame_abort));
